// ### dv/rwc_chk.sv
// Concurrent checks on the interface between the core end and the device.
// Assumes the interface signals, the clock and the power-up reset as inputs.
`timescale 1ns/1ps
module rwc_chk (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// Interface signals
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic wd_restart,
	input wire logic irq_ack,
	input wire logic wd_irq,
	input wire logic core_reset
);
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	logic [2:0] since_ul;
	wire ul_wr = wr && addr == 4'h0 && wdata[4] && wdata[3];
	// Cycles since the last unlock write, saturating at seven.
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in)
			since_ul <= 3'h7;
		else if (ul_wr)
			since_ul <= 3'h0;
		else if (since_ul != 3'h7)
			since_ul <= since_ul + 3'h1;
	end
	sequence s_ctrl_rd;
		rd && addr == 4'h0;
	endsequence
	sequence s_unlock_seen;
		s_ctrl_rd ##1 rdata[4];
	endsequence
	property p_unlock_window;
		s_unlock_seen |-> $past(since_ul) <= 3'h4;
	endproperty
	a_unlock_window: assert property (p_unlock_window)
		else $error("unlock bit seen outside its window");
	property p_rst_stretch;
		$rose(core_reset) |-> core_reset [*8];
	endproperty
	a_rst_stretch: assert property (p_rst_stretch)
		else $error("core reset shorter than the delay");
	property p_irq_ack;
		irq_ack |-> ##[1:2] !wd_irq;
	endproperty
	a_irq_ack: assert property (p_irq_ack)
		else $error("interrupt not cleared by acknowledge");
	property p_restart_quiet;
		wd_restart |=> (!$rose(wd_irq)) [*8];
	endproperty
	a_restart_quiet: assert property (p_restart_quiet)
		else $error("time-out right after restart");
	property p_reset_quiet;
		core_reset && $past(core_reset) |-> !wd_irq;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet)
		else $error("interrupt during reset");
	property p_status;
		rd && addr == 4'h2 |=> rdata[0] == $past(core_reset);
	endproperty
	a_status: assert property (p_status)
		else $error("status disagrees with core reset");
	property p_irq_no_reset;
		$rose(wd_irq) |-> !core_reset ##1 !core_reset;
	endproperty
	a_irq_no_reset: assert property (p_irq_no_reset)
		else $error("reset with the first time-out");
	property p_rd_idle;
		!$past(rd) |-> rdata == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside a read");
endmodule

// ### dv/tb.sv
// Self-checking bench joining both ends of the reset and watchdog block.
// Assumes small delay and watchdog counts to keep the run short.
`timescale 1ns/1ps
module tb;
	// ----------------------------------------
	// Bench
	// ----------------------------------------
	localparam int DS = 8;
	localparam int DL = 16;
	localparam int WV = 4;
	localparam int WB = 4;
	logic mclk_in = 0, rst_in = 1, pin_n = 1, chg = 0, uv = 0, jtag = 0;
	logic fuse_on = 0, dly_fuse = 0, wr = 0, rd = 0, kick = 0, ack = 0, dly;
	logic [3:0] addr = 0, pv;
	logic [7:0] wdata = 0, rdata;
	logic irq, core_rst, port_rst, bod_en, pwr_off;
	int fails = 0, n_compared = 0, n, t;
	rwc_if u_rwc_if();
	always #2.5 mclk_in = ~mclk_in;
	rwc_device #(.DELAY_SHORT(DS), .DELAY_LONG(DL), .WD_DIV(WV), .WD_BASE(WB)) u_rwc_device (
		.mclk_in(mclk_in), .rst_in(rst_in), .reset_pin_n_in(pin_n), .charger_detect_in(chg),
		.undervoltage_in(uv), .jtag_reset_in(jtag), .power_off_req_in(1'b0), .sleep_in(1'b0),
		.fuse_watchdog_forced_on_in(fuse_on), .startup_delay_fuses_in(dly_fuse),
		.bus(u_rwc_if.device), .port_reset_out(port_rst), .bod_enable_out(bod_en),
		.power_off_out(pwr_off));
	rwc_core_end u_rwc_core_end (.mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr),
		.wdata_in(wdata), .wr_in(wr), .rd_in(rd), .restart_in(kick), .irq_ack_in(ack),
		.rdata_out(rdata), .irq_out(irq), .core_reset_out(core_rst), .bus(u_rwc_if.core));
	rwc_chk u_rwc_chk (.mclk_in(mclk_in), .rst_in(rst_in), .addr(u_rwc_if.addr),
		.wdata(u_rwc_if.wdata), .wr(u_rwc_if.wr), .rd(u_rwc_if.rd), .rdata(u_rwc_if.rdata),
		.wd_restart(u_rwc_if.wd_restart), .irq_ack(u_rwc_if.irq_ack),
		.wd_irq(u_rwc_if.wd_irq), .core_reset(u_rwc_if.core_reset));
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic op(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		wr <= w;
		rd <= r;
		addr <= a;
		wdata <= d;
	endtask
	task automatic wrt(input logic [3:0] a, input logic [7:0] d);
		op(1, 0, a, d);
		op(0, 0, 0, 0);
	endtask
	// Read data arrive three edges after the read is driven.
	task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
		op(0, 1, a, 0);
		op(0, 0, 0, 0);
		repeat (2) @(posedge mclk_in);
		#1 cmp(rdata, exp);
	endtask
	// Unlock, then write the new setting at once.
	task automatic setc(input logic [7:0] d);
		op(1, 0, 0, 8'h18);
		op(1, 0, 0, d);
		op(0, 0, 0, 0);
	endtask
	task automatic wt(input bit s, input logic v);
		n = 0;
		while ((s ? irq : core_rst) !== v && n < 20000) begin
			@(posedge mclk_in);
			#1 n++;
		end
		if (n >= 20000) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, !v, v);
		end
	endtask
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		void'($urandom(13270));
		repeat (3) @(posedge mclk_in);
		rst_in <= 0;
		rdc(2, 8'h03);
		cmp({bod_en, pwr_off}, 8'h01);
		chg <= 1;
		wt(0, 0);
		cmp(n >= DS, 1);
		rdc(1, 8'h01);
		rdc(0, 8'h00);
		wrt(1, 0);
		$display("test power_up done");
		kick <= 1;
		wrt(0, 8'h08);
		rdc(0, 8'h08);
		wrt(0, 8'h01);
		rdc(0, 8'h08);
		op(1, 0, 0, 8'h10);
		wrt(0, 8'h00);
		rdc(0, 8'h08);
		op(1, 0, 0, 8'h18);
		repeat (4) op(0, 0, 0, 0);
		wrt(0, 8'h00);
		rdc(0, 8'h08);
		op(1, 0, 0, 8'h18);
		repeat (2) op(0, 0, 0, 0);
		wrt(0, 8'h01);
		rdc(0, 8'h01);
		for (int i = 0; i < 4; i++) begin
			pv = 4'($urandom_range(9, 0));
			setc({2'b00, pv[3], 2'b01, pv[2:0]});
			rdc(0, {2'b00, pv[3], 2'b01, pv[2:0]});
		end
		$display("test unlock done");
		pv = 4'($urandom_range(2, 0));
		setc({2'b01, pv[3], 2'b01, pv[2:0]});
		t = (WB << pv) * WV;
		kick <= 0;
		wt(1, 1);
		cmp(n >= t - WV && n <= t + 2 * WV + 6, 1);
		cmp(core_rst, 0);
		@(posedge mclk_in);
		ack <= 1;
		@(posedge mclk_in);
		ack <= 0;
		rdc(0, {2'b00, pv[3], 2'b01, pv[2:0]});
		wt(0, 1);
		cmp(irq, 0);
		wt(0, 0);
		kick <= 1;
		rdc(1, 8'h08);
		rdc(0, 8'h08);
		setc(8'h00);
		rdc(0, 8'h08);
		wrt(1, 0);
		setc(8'h00);
		rdc(0, 8'h00);
		$display("test combined done");
		fuse_on <= 1;
		wrt(0, 8'h40);
		rdc(0, 8'h08);
		fuse_on <= 0;
		setc(8'h00);
		$display("test fuse done");
		for (int i = 0; i < 3; i++) begin
			dly = 1'($urandom_range(1, 0));
			@(posedge mclk_in);
			pin_n <= (i != 0);
			uv <= (i == 1);
			jtag <= (i == 2);
			dly_fuse <= dly;
			#1 cmp(port_rst, 1);
			repeat (30) @(posedge mclk_in);
			cmp(core_rst, 1);
			pin_n <= 1;
			uv <= 0;
			jtag <= 0;
			t = dly ? DL : DS;
			wt(0, 0);
			cmp(n >= t && n <= t + 8, 1);
			cmp(bod_en, 1);
			rdc(1, 8'h02 << (i + i / 2));
			wrt(1, 0);
		end
		$display("test reset_sources done");
		end_of_test();
	end
	initial begin
		#200us;
		fails++;
		end_of_test();
	end
endmodule

// ### hdl/rwc_core_end.sv
// Processor-side end: turns user requests into register accesses on rwc_if.
// Assumes the same clock as the device; device outputs are already in this domain.
`timescale 1ns/1ps
`include "rwc_map.svh"
module rwc_core_end
	import rwc_pkg::*;
(
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// User side
	input wire logic [3:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic restart_in,
	input wire logic irq_ack_in,
	output logic [7:0] rdata_out,
	output logic irq_out,
	output logic core_reset_out,
	// Device side
	rwc_if.core bus
);
	logic [3:0] addr;
	logic [7:0] wdata, rdata;
	logic wr, rd, restart, ack, irq, crst;
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			addr <= 4'h0;
			wdata <= 8'h00;
			wr <= 1'b0;
			rd <= 1'b0;
			restart <= 1'b0;
			ack <= 1'b0;
			rdata <= 8'h00;
			irq <= 1'b0;
			crst <= 1'b1;
		end else begin
			addr <= addr_in;
			wdata <= wdata_in;
			wr <= wr_in;
			rd <= rd_in & ~wr_in;
			restart <= restart_in;
			ack <= irq_ack_in;
			rdata <= bus.rdata;
			irq <= bus.wd_irq;
			crst <= bus.core_reset;
		end
	end
	assign bus.addr = addr;
	assign bus.wdata = wdata;
	assign bus.wr = wr;
	assign bus.rd = rd;
	assign bus.wd_restart = restart;
	assign bus.irq_ack = ack;
	assign rdata_out = rdata;
	assign irq_out = irq;
	assign core_reset_out = crst;
endmodule

// ### hdl/rwc_device.sv
// Reset controller and watchdog timer of the device.
// Assumes a 200 MHz clock, asynchronous raw reset sources, and a core on rwc_if.
// Overview of operation
// - Any reset loads registers, restarts core.
// - Port reset is asynchronous, needs no clock; watchdog and charger resets are clocked here.
// - Stretch reset by fuse-chosen delay count.
// - Charger detect in power-off gives reset.
// - Long enough low reset pin resets.
// - Watchdog reset is one cycle pulse.
// - Undervoltage detector active except power-off.
// - Undervoltage resets now, delays on recovery.
// - JTAG reset register holds core reset.
// - Watchdog counts 128 kHz oscillator ticks.
// - Restart instruction clears watchdog counter.
// - Interrupt mode raises wake-capable request.
// - Reset mode resets on expiry.
// - Combined mode interrupts then becomes reset.
// - Always-on fuse forces reset mode.
// - Unlock needs unlock and enable together.
// - Change accepted within four cycles after unlock.
// - Periods span 16 ms to 8 s.
// - Watchdog runs in sleep, stops power-off.
// - Unlock bit self-clears after four cycles.
// - Cause flag forces reset enable set.
// - Vector entry clears flag, and enable when reset enabled.
// - Cause flag cleared by power-up or zero.
`timescale 1ns/1ps
`include "rwc_map.svh"
module rwc_device
	import rwc_pkg::*;
#(
	parameter int DELAY_SHORT = `RWC_DELAY_SHORT,
	parameter int DELAY_LONG = `RWC_DELAY_LONG,
	parameter int WD_DIV = `RWC_WD_DIV,
	parameter int WD_BASE = `RWC_WD_BASE_CYCLES
) (
	// Clock and power-up reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// Raw reset sources, power-off and sleep requests from outside the clock domain
	input wire logic reset_pin_n_in,
	input wire logic charger_detect_in,
	input wire logic undervoltage_in,
	input wire logic jtag_reset_in,
	input wire logic power_off_req_in,
	input wire logic sleep_in,
	// Fuses
	input wire logic fuse_watchdog_forced_on_in,
	input wire logic startup_delay_fuses_in,
	// Core side
	rwc_if.device bus,
	// Outputs
	output logic port_reset_out,
	output logic bod_enable_out,
	output logic power_off_out
);
	logic [1:0] pin_s, chg_s, uv_s, jt_s, off_s;
	logic [7:0] rdata;
	logic wd_irq, core_reset, port_reset, bod_en;
	rwc_state_e state, next_state;
	logic [16:0] delay_cnt;
	logic [15:0] div_cnt;
	logic [20:0] wd_cnt;
	logic wd_rst_pulse, wd_to_flag, wd_irq_en, wd_rst_en, wd_unlock;
	logic [3:0] wd_period;
	logic [2:0] unlock_cnt;
	logic [4:0] cause;
	// ----------------------------------------------------------------
	// Synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			pin_s <= 2'h3;
			chg_s <= 2'h0;
			uv_s <= 2'h0;
			jt_s <= 2'h0;
			off_s <= 2'h0;
		end else begin
			pin_s <= {pin_s[0], reset_pin_n_in};
			chg_s <= {chg_s[0], charger_detect_in};
			uv_s <= {uv_s[0], undervoltage_in};
			jt_s <= {jt_s[0], jtag_reset_in};
			off_s <= {off_s[0], power_off_req_in};
		end
	end
	wire is_off = (state == RWC_OFF);
	wire uv_act = uv_s[1] & ~is_off;
	wire ext_act = ~pin_s[1];
	wire jt_act = jt_s[1];
	wire por_evt = is_off & chg_s[1];
	wire src_act = ext_act | uv_act | jt_act | wd_rst_pulse | por_evt;
	// asynchronous port reset, no clock needed
	wire async_src = rst_in | ~reset_pin_n_in | (undervoltage_in & bod_en) | jtag_reset_in;
	wire [16:0] delay_len = startup_delay_fuses_in ? 17'(DELAY_LONG) : 17'(DELAY_SHORT);
	// ----------------------------------------------------------------
	// Reset sequencer
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			RWC_OFF: begin
				if (por_evt)
					next_state = RWC_RESET;
			end
			RWC_RESET: begin
				if (!src_act && delay_cnt == 17'h0)
					next_state = RWC_ACTIVE;
			end
			RWC_ACTIVE: begin
				if (src_act)
					next_state = RWC_RESET;
				else if (off_s[1])
					next_state = RWC_OFF;
			end
			default: next_state = RWC_OFF;
		endcase
	end
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			state <= RWC_OFF;
			delay_cnt <= 17'h0;
		end else begin
			state <= next_state;
			if (src_act || next_state == RWC_OFF)
				delay_cnt <= delay_len;
			else if (delay_cnt != 17'h0)
				delay_cnt <= delay_cnt - 17'h1;
		end
	end
	// port reset driven asynchronously from power-up, pin, undervoltage and JTAG; watchdog and charger resets are clocked
	always_ff @(posedge mclk_in or posedge async_src) begin
		if (async_src)
			port_reset <= 1'b1;
		else
			port_reset <= (next_state != RWC_ACTIVE);
	end
	// ----------------------------------------------------------------
	// Watchdog
	// ----------------------------------------------------------------
	// forced mode
	wire eff_rst_en = fuse_watchdog_forced_on_in | wd_rst_en | cause[`RWC_CAUSE_WD];
	wire eff_irq_en = wd_irq_en & ~fuse_watchdog_forced_on_in;
	wire wd_run = (eff_rst_en | eff_irq_en) & ~is_off;
	wire wd_tick = (div_cnt == 16'(WD_DIV - 1));
	wire [20:0] wd_limit = 21'(WD_BASE) << wd_period[3:0];
	wire wd_expire = wd_run & wd_tick & (wd_cnt >= wd_limit - 21'h1);
	wire core_active = (state == RWC_ACTIVE);
	wire ctrl_wr = bus.wr & (bus.addr == `RWC_ADDR_CTRL) & core_active;
	wire cause_wr = bus.wr & (bus.addr == `RWC_ADDR_CAUSE) & core_active;
	wire wr_unlock = bus.wdata[`RWC_CTRL_UNLOCK] & bus.wdata[`RWC_CTRL_RST_EN];
	wire [3:0] wr_per = {bus.wdata[`RWC_CTRL_PER_HI], bus.wdata[2:0]};
	wire irq_mode_hit = wd_expire & eff_irq_en;
	// reset only when interrupt not enabled
	wire rst_hit = wd_expire & eff_rst_en & ~eff_irq_en;
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			div_cnt <= 16'h0;
			wd_cnt <= 21'h0;
		end else begin
			div_cnt <= wd_tick ? 16'h0 : div_cnt + 16'h1;
			if (bus.wd_restart || !wd_run || wd_expire || !core_active)
				wd_cnt <= 21'h0;
			else if (wd_tick)
				wd_cnt <= wd_cnt + 21'h1;
		end
	end
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			wd_rst_pulse <= 1'b0;
			wd_to_flag <= 1'b0;
			wd_irq_en <= 1'b0;
			wd_rst_en <= 1'b0;
			wd_unlock <= 1'b0;
			wd_period <= 4'h0;
			unlock_cnt <= 3'h0;
		end else if ((src_act || !core_active) && !wd_rst_pulse) begin
			wd_rst_pulse <= 1'b0;
			wd_to_flag <= 1'b0;
			wd_irq_en <= 1'b0;
			wd_rst_en <= 1'b0;
			wd_unlock <= 1'b0;
			wd_period <= 4'h0;
			unlock_cnt <= 3'h0;
		end else begin
			wd_rst_pulse <= rst_hit & ~wd_rst_pulse;
			if (wd_unlock)
				unlock_cnt <= unlock_cnt + 3'h1;
			if (wd_unlock && unlock_cnt == 3'(`RWC_UNLOCK_CYCLES - 1))
				wd_unlock <= 1'b0;
			if (ctrl_wr) begin
				wd_irq_en <= bus.wdata[`RWC_CTRL_IRQ_EN];
				if (wr_unlock) begin
					wd_unlock <= 1'b1;
					unlock_cnt <= 3'h0;
					wd_rst_en <= 1'b1;
				end else if (wd_unlock) begin
					wd_rst_en <= bus.wdata[`RWC_CTRL_RST_EN];
					wd_period <= wr_per;
					wd_unlock <= 1'b0;
				end else if (bus.wdata[`RWC_CTRL_RST_EN]) begin
					wd_rst_en <= 1'b1;
				end
			end
			if (irq_mode_hit) begin
				wd_to_flag <= 1'b1;
			end else if (bus.irq_ack && wd_to_flag) begin
				wd_to_flag <= 1'b0;
				if (eff_rst_en)
					wd_irq_en <= 1'b0;
			end else if (ctrl_wr && bus.wdata[`RWC_CTRL_TO_FLAG]) begin
				wd_to_flag <= 1'b0;
			end
		end
	end
	// ----------------------------------------------------------------
	// Reset cause flags
	// ----------------------------------------------------------------
	wire [4:0] cause_set = {jt_act, wd_rst_pulse, uv_act, ext_act, por_evt};
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			cause <= 5'h0;
		end else if (por_evt) begin
			cause <= 5'h01;
		end else begin
			// set wins over write of zero
			if (cause_wr)
				cause <= (cause & bus.wdata[4:0]) | cause_set;
			else
				cause <= cause | cause_set;
		end
	end
	// ----------------------------------------------------------------
	// Read port and outputs
	// ----------------------------------------------------------------
	// enable reads set under cause flag
	wire [7:0] ctrl_view = {wd_to_flag, eff_irq_en, wd_period[3], wd_unlock, eff_rst_en,
		wd_period[2:0]};
	wire [7:0] stat_view = {6'h0, is_off, core_reset};
	wire [7:0] rd_mux = (bus.addr == `RWC_ADDR_CTRL) ? ctrl_view :
		(bus.addr == `RWC_ADDR_CAUSE) ? {3'h0, cause} :
		(bus.addr == `RWC_ADDR_STATUS) ? stat_view : 8'h00;
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			rdata <= 8'h00;
			wd_irq <= 1'b0;
			core_reset <= 1'b1;
			bod_en <= 1'b0;
		end else begin
			rdata <= bus.rd ? rd_mux : 8'h00;
			wd_irq <= wd_to_flag & eff_irq_en;
			core_reset <= (next_state != RWC_ACTIVE);
			bod_en <= (next_state != RWC_OFF);
		end
	end
	assign bus.rdata = rdata;
	assign bus.wd_irq = wd_irq;
	assign bus.core_reset = core_reset;
	assign port_reset_out = port_reset;
	assign bod_enable_out = bod_en;
	assign power_off_out = is_off;
	wire unused_sleep = sleep_in;
endmodule

// ### hdl/rwc_if.sv
// Interface joining the processor side and the reset and watchdog device.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface rwc_if;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	logic wd_restart;
	logic irq_ack;
	logic wd_irq;
	logic core_reset;
	modport device (
		input addr, wdata, wr, rd, wd_restart, irq_ack,
		output rdata, wd_irq, core_reset
	);
	modport core (
		output addr, wdata, wr, rd, wd_restart, irq_ack,
		input rdata, wd_irq, core_reset
	);
endinterface

// ### hdl/rwc_map.svh
// Offsets, field positions, reset values and timing counts of the reset and watchdog block.
// Assumes inclusion by bare name from both ends.
`ifndef RWC_MAP_SVH
`define RWC_MAP_SVH
// Register indices on the device register port.
`define RWC_ADDR_CTRL 4'h0
`define RWC_ADDR_CAUSE 4'h1
`define RWC_ADDR_STATUS 4'h2
// Control register fields.
`define RWC_CTRL_PER_LO 0
`define RWC_CTRL_RST_EN 3
`define RWC_CTRL_UNLOCK 4
`define RWC_CTRL_PER_HI 5
`define RWC_CTRL_IRQ_EN 6
`define RWC_CTRL_TO_FLAG 7
// Cause register fields.
`define RWC_CAUSE_POWER 0
`define RWC_CAUSE_EXT 1
`define RWC_CAUSE_UV 2
`define RWC_CAUSE_WD 3
`define RWC_CAUSE_JTAG 4
// Status register fields.
`define RWC_STAT_RESET 0
`define RWC_STAT_OFF 1
// Reset values.
`define RWC_CTRL_RESET 8'h00
`define RWC_CAUSE_RESET 8'h00
// Timing.
`define RWC_SYS_CLK_HZ 200000000
`define RWC_WD_OSC_HZ 128000
`define RWC_WD_DIV ((`RWC_SYS_CLK_HZ + `RWC_WD_OSC_HZ - 1) / `RWC_WD_OSC_HZ)
`define RWC_UNLOCK_CYCLES 4
`define RWC_WD_BASE_CYCLES 2048
`define RWC_DELAY_SHORT 4096
`define RWC_DELAY_LONG 65536
`endif

// ### hdl/rwc_pkg.sv
// Types shared by both ends of the reset and watchdog block.
// Assumes rwc_map.svh for numeric constants.
package rwc_pkg;
	typedef enum logic [2:0] {
		RWC_OFF = 3'b001,
		RWC_RESET = 3'b010,
		RWC_ACTIVE = 3'b100
	} rwc_state_e;
	typedef logic [7:0] rwc_byte_t;
endpackage
